// ### hdl/odc_defines.vh
// Constants for the output divider combo and phase configuration block
`ifndef ODC_DEFINES_VH
`define ODC_DEFINES_VH
// Register word indices (printed offsets are not all multiples of four)
`define ODC_IDX_GEN        4'h0
`define ODC_IDX_PHASE      4'h2
`define ODC_IDX_NUM_LO     4'h4
`define ODC_IDX_NUM_HI     4'h5
`define ODC_IDX_DEN_LO     4'h6
`define ODC_IDX_DEN_HI     4'h7
`define ODC_IDX_FRAC_LO    4'h8
`define ODC_IDX_DIVHI      4'h9
`define ODC_IDX_OFS_LO     4'hA
`define ODC_IDX_OFS_HI     4'hB
`define ODC_IDX_TRIG       4'hC
`define ODC_IDX_SUM_LO     4'hD
`define ODC_IDX_SUM_HI     4'hE
// General configuration fields
`define ODC_GEN_RESET      16'h0014
`define ODC_GEN_RW_MASK    16'hFFF3
`define ODC_GEN_RSV_VAL    16'h0004
`define ODC_B_FREEZE       15
`define ODC_F_LAFB_HI      14
`define ODC_F_LAFB_LO      13
`define ODC_F_LC_HI        12
`define ODC_F_LC_LO        11
`define ODC_F_LB_HI        10
`define ODC_F_LB_LO        9
`define ODC_F_LA_HI        8
`define ODC_F_LA_LO        7
`define ODC_F_TS_HI        6
`define ODC_F_TS_LO        5
`define ODC_B_POSTSYNC     4
`define ODC_B_SYNCMODE     1
`define ODC_PH_W           10
// Operator encodings
`define ODC_OP_ZERO        2'h0
`define ODC_OP_ADD         2'h1
`define ODC_OP_SUB         2'h2
// Divider defaults
`define ODC_INT_RESET      9'h014
`define ODC_DEN_RESET      40'h8000000000
`endif

// ### hdl/odc_term_sel.v
// One combo input term under a two-bit zero/add/subtract operator
`default_nettype none
module odc_term_sel #(
   parameter W = 40
) (
   input  wire [1:0]   op,
   input  wire [W-1:0] term_in,
   output reg  [W-1:0] term_out
);
`include "odc_defines.vh"
   always @* begin
      case (op)
         `ODC_OP_ADD: term_out = term_in;
         `ODC_OP_SUB: term_out = {W{1'b0}} - term_in;
         default:     term_out = {W{1'b0}};   // Reserved code acts as zero
      endcase
   end
endmodule // odc_term_sel
`default_nettype wire

// ### hdl/odc_cfg.v
// Output divider combo sum, sync mode and phase step configuration
`default_nettype none
`include "odc_defines.vh"
// How it works
// - Freeze bit clear: combo sum recomputed every cycle and sent on.
// - Freeze rising edge captures the sum; held until the bit clears.
// - Loop A feedback offset term: 0 zero, 1 add, 2 subtract, 3 reserved.
// - Loop C delta term: 0 zero, 1 add, 2 subtract, 3 reserved.
// - Loop B delta term: 0 zero, 1 add, 2 subtract, 3 reserved.
// - Loop A delta term: 0 zero, 1 add, 2 subtract, 3 reserved.
// - Time sync delta term: 0 zero, 1 add, 2 subtract, 3 reserved.
// - Post-resync phase bit selects step after resync; resets to 1.
// - Sync mode 0 ignores numerator and denominator; 1 uses them.
// - Phase step is signed 10 bits, quarter VCO period per step.
// - Writing the trigger bit as 1 applies the stored phase step.
// - Post-resync bit set: step applied right after every resync.
// - Non-sync ratio uses 40 fraction bits; sync uses low 16 only.
// - Sync ratio: integer plus (fraction16 + num/den) over 2^16.
// - Signed offset added to the sum of all selected combo inputs.
module odc_cfg #(
   parameter SW = 40,
   parameter OW = 39
) (
   input  wire          ref_clk,
   input  wire          sys_rst,
   input  wire [5:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output reg  [31:0]   avs_readdata,
   output reg           avs_waitrequest,
   input  wire [SW-1:0] loop_a_feedback_offset,
   input  wire [SW-1:0] loop_a_delta,
   input  wire [SW-1:0] loop_b_delta,
   input  wire [SW-1:0] loop_c_delta,
   input  wire [SW-1:0] timesync_delta,
   input  wire          divider_resync,
   output reg  [SW-1:0] combo_sum_out,
   output reg           sync_mode_en,
   output reg  [8:0]    div_integer,
   output reg  [39:0]   div_fraction,
   output reg  [39:0]   div_numerator,
   output reg  [39:0]   div_denominator,
   output reg           div_load,
   output reg  [9:0]    phase_step,
   output reg           phase_step_apply
);
   ////////////////////////////////////////////////////////////////////////////
   reg  [15:0]       gen_r;
   reg  [`ODC_PH_W-1:0] phase_r;
   reg  [39:0]       num_r;
   reg  [39:0]       den_r;
   reg  [39:0]       frac_r;
   reg  [8:0]        int_r;
   reg  [OW-1:0]     ofs_r;
   reg  [SW-1:0]     held_r;
   reg               freeze_q_r;
   reg               acc_r;
   reg  [31:0]       rd_nxt;
   reg  [31:0]       wmask;
   reg  [SW-1:0]     sum_nxt;
   wire [3:0]        idx = avs_address[5:2];
   wire              wr_go = avs_write & acc_r;
   wire              rd_go = avs_read & acc_r;
   wire              freeze = gen_r[`ODC_B_FREEZE];
   wire [SW-1:0]     t_fb;
   wire [SW-1:0]     t_la;
   wire [SW-1:0]     t_lb;
   wire [SW-1:0]     t_lc;
   wire [SW-1:0]     t_ts;
   wire [SW-1:0]     ofs_ext = {{(SW-OW){ofs_r[OW-1]}}, ofs_r};

   always @* begin
      wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Term operators
   odc_term_sel #(.W(SW)) u_fb (.op(gen_r[`ODC_F_LAFB_HI:`ODC_F_LAFB_LO]),
      .term_in(loop_a_feedback_offset), .term_out(t_fb));
   odc_term_sel #(.W(SW)) u_lc (.op(gen_r[`ODC_F_LC_HI:`ODC_F_LC_LO]),
      .term_in(loop_c_delta), .term_out(t_lc));
   odc_term_sel #(.W(SW)) u_lb (.op(gen_r[`ODC_F_LB_HI:`ODC_F_LB_LO]),
      .term_in(loop_b_delta), .term_out(t_lb));
   odc_term_sel #(.W(SW)) u_la (.op(gen_r[`ODC_F_LA_HI:`ODC_F_LA_LO]),
      .term_in(loop_a_delta), .term_out(t_la));
   odc_term_sel #(.W(SW)) u_ts (.op(gen_r[`ODC_F_TS_HI:`ODC_F_TS_LO]),
      .term_in(timesync_delta), .term_out(t_ts));

   always @* begin
      sum_nxt = t_fb + t_la + t_lb + t_lc + t_ts + ofs_ext;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Combo sum: live while unfrozen, captured on the freeze edge
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         held_r        <= {SW{1'b0}};
         freeze_q_r    <= 1'b0;
         combo_sum_out <= {SW{1'b0}};
      end else begin
         freeze_q_r <= freeze;
         if (freeze && !freeze_q_r) begin
            held_r <= sum_nxt;
         end
         if (!freeze) begin
            combo_sum_out <= sum_nxt;
         end else if (!freeze_q_r) begin
            combo_sum_out <= sum_nxt;
         end else begin
            combo_sum_out <= held_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; one wait cycle per access
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_r   <= 1'b0;
         gen_r   <= `ODC_GEN_RESET;
         phase_r <= {`ODC_PH_W{1'b0}};
         num_r   <= 40'h0000000000;
         den_r   <= `ODC_DEN_RESET;
         frac_r  <= 40'h0000000000;
         int_r   <= `ODC_INT_RESET;
         ofs_r   <= {OW{1'b0}};
      end else begin
         acc_r <= (avs_read | avs_write) & ~acc_r;
         if (wr_go) begin
            case (idx)
               `ODC_IDX_GEN: gen_r <= ((gen_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]))
                                      & `ODC_GEN_RW_MASK | `ODC_GEN_RSV_VAL;
               `ODC_IDX_PHASE: phase_r <= (phase_r & ~wmask[9:0]) | (avs_writedata[9:0] & wmask[9:0]);
               `ODC_IDX_NUM_LO: num_r[31:0] <= (num_r[31:0] & ~wmask) | (avs_writedata & wmask);
               `ODC_IDX_NUM_HI: num_r[39:32] <= (num_r[39:32] & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
               `ODC_IDX_DEN_LO: den_r[31:0] <= (den_r[31:0] & ~wmask) | (avs_writedata & wmask);
               `ODC_IDX_DEN_HI: den_r[39:32] <= (den_r[39:32] & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
               `ODC_IDX_FRAC_LO: frac_r[31:0] <= (frac_r[31:0] & ~wmask) | (avs_writedata & wmask);
               `ODC_IDX_DIVHI: begin
                  frac_r[39:32] <= (frac_r[39:32] & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
                  int_r <= (int_r & ~wmask[16:8]) | (avs_writedata[16:8] & wmask[16:8]);
               end
               `ODC_IDX_OFS_LO: ofs_r[31:0] <= (ofs_r[31:0] & ~wmask) | (avs_writedata & wmask);
               `ODC_IDX_OFS_HI: ofs_r[OW-1:32] <= (ofs_r[OW-1:32] & ~wmask[OW-33:0])
                                                  | (avs_writedata[OW-33:0] & wmask[OW-33:0]);
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divider integer goes out with div_load when the integer word is written; fraction follows every cycle, numerator and denominator only in sync mode
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_integer     <= `ODC_INT_RESET;
         div_fraction    <= 40'h0000000000;
         div_numerator   <= 40'h0000000000;
         div_denominator <= `ODC_DEN_RESET;
         sync_mode_en    <= 1'b0;
         div_load        <= 1'b0;
      end else begin
         div_load     <= 1'b0;
         sync_mode_en <= gen_r[`ODC_B_SYNCMODE];
         if (!gen_r[`ODC_B_SYNCMODE]) begin
            div_numerator   <= 40'h0000000000;
            div_denominator <= `ODC_DEN_RESET;
         end else begin
            div_numerator   <= num_r;
            div_denominator <= den_r;
         end
         if (gen_r[`ODC_B_SYNCMODE])
            div_fraction <= {24'h000000, frac_r[15:0]};
         else
            div_fraction <= frac_r;
         if (wr_go && idx == `ODC_IDX_DIVHI && avs_byteenable[1]) begin
            div_integer <= avs_writedata[16:8];
            div_load    <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase step issue. Multiples of four in integer mode are software's job.
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_step       <= 10'h000;
         phase_step_apply <= 1'b0;
      end else begin
         phase_step_apply <= 1'b0;
         if (wr_go && idx == `ODC_IDX_TRIG && avs_byteenable[0] && avs_writedata[0]) begin
            phase_step       <= phase_r;
            phase_step_apply <= 1'b1;
         end else if (divider_resync && gen_r[`ODC_B_POSTSYNC]) begin
            phase_step       <= phase_r;
            phase_step_apply <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped words read zero
   always @* begin
      case (idx)
         `ODC_IDX_GEN:     rd_nxt = {16'h0000, gen_r};
         `ODC_IDX_PHASE:   rd_nxt = {22'h000000, phase_r};
         `ODC_IDX_NUM_LO:  rd_nxt = num_r[31:0];
         `ODC_IDX_NUM_HI:  rd_nxt = {24'h000000, num_r[39:32]};
         `ODC_IDX_DEN_LO:  rd_nxt = den_r[31:0];
         `ODC_IDX_DEN_HI:  rd_nxt = {24'h000000, den_r[39:32]};
         `ODC_IDX_FRAC_LO: rd_nxt = frac_r[31:0];
         `ODC_IDX_DIVHI:   rd_nxt = {15'h0000, int_r, frac_r[39:32]};
         `ODC_IDX_OFS_LO:  rd_nxt = ofs_r[31:0];
         `ODC_IDX_OFS_HI:  rd_nxt = {{(64-OW){ofs_r[OW-1]}}, ofs_r[OW-1:32]};
         `ODC_IDX_SUM_LO:  rd_nxt = combo_sum_out[31:0];
         `ODC_IDX_SUM_HI:  rd_nxt = {{(64-SW){combo_sum_out[SW-1]}}, combo_sum_out[SW-1:32]};
         default:          rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata    <= 32'h00000000;
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & ~acc_r);
         if (avs_read && !acc_r)
            avs_readdata <= rd_nxt;
         else if (!rd_go)
            avs_readdata <= 32'h00000000;
      end
   end
endmodule // odc_cfg
`default_nettype wire

// ### tb/odc_cfg_chk.sv
// Concurrent checks on the ports of the output divider configuration block
`default_nettype none
`include "odc_defines.vh"
module odc_cfg_chk #(
   parameter SW = 40
) (
   input wire logic          ref_clk,
   input wire logic          sys_rst,
   input wire logic [5:0]    avs_address,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic [31:0]   avs_writedata,
   input wire logic          avs_waitrequest,
   input wire logic [SW-1:0] loop_a_feedback_offset,
   input wire logic [SW-1:0] loop_a_delta,
   input wire logic [SW-1:0] loop_b_delta,
   input wire logic [SW-1:0] loop_c_delta,
   input wire logic [SW-1:0] timesync_delta,
   input wire logic          divider_resync,
   input wire logic [SW-1:0] combo_sum_out,
   input wire logic          sync_mode_en,
   input wire logic          div_load,
   input wire logic          phase_step_apply
);
   ////////////////////////////////////////////////////////////
   // Shadow of the general register; offset is assumed left at zero
   logic [15:0] sh_r;
   wire logic          wacc = avs_write && !avs_waitrequest;
   wire logic          trig = wacc && avs_address[5:2] == `ODC_IDX_TRIG && avs_writedata[0];
   wire logic          rsy  = divider_resync && sh_r[4];
   function automatic logic [SW-1:0] tm(input logic [1:0] o, input logic [SW-1:0] v);
      tm = (o == 2'h1) ? v : (o == 2'h2) ? -v : {SW{1'b0}};
   endfunction
   wire logic [SW-1:0] sum_c = tm(sh_r[14:13], loop_a_feedback_offset) + tm(sh_r[12:11], loop_c_delta)
                             + tm(sh_r[10:9], loop_b_delta) + tm(sh_r[8:7], loop_a_delta) + tm(sh_r[6:5], timesync_delta);
   always_ff @(posedge ref_clk or posedge sys_rst)
      if (sys_rst) sh_r <= `ODC_GEN_RESET;
      else if (wacc && avs_address[5:2] == `ODC_IDX_GEN) sh_r <= (avs_writedata[15:0] & `ODC_GEN_RW_MASK) | `ODC_GEN_RSV_VAL;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_sum; !$past(sh_r[15]) && !$past(sys_rst) |-> combo_sum_out == $past(sum_c); endproperty
   a_sum: assert property (p_sum) else $error("combo sum does not track inputs");
   property p_frz; sh_r[15] && $past(sh_r[15]) && $past(sh_r[15], 2) |-> $stable(combo_sum_out); endproperty
   a_frz: assert property (p_frz) else $error("frozen combo sum moved");
   property p_sm; sync_mode_en == $past(sh_r[1]); endproperty
   a_sm: assert property (p_sm) else $error("sync mode output wrong");
   property p_trg; trig |-> ##[1:2] phase_step_apply; endproperty
   a_trg: assert property (p_trg) else $error("trigger gave no phase step");
   property p_rsy; rsy |-> ##[1:2] phase_step_apply; endproperty
   a_rsy: assert property (p_rsy) else $error("resync gave no phase step");
   property p_spur; phase_step_apply |-> $past(trig) || $past(rsy) || $past(trig, 2) || $past(rsy, 2); endproperty
   a_spur: assert property (p_spur) else $error("phase step without cause");
   property p_ld; wacc && avs_address[5:2] == `ODC_IDX_DIVHI |-> ##[1:2] div_load; endproperty
   a_ld: assert property (p_ld) else $error("integer write gave no load");
   property p_ws; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_ws: assert property (p_ws) else $error("waitrequest low too long");
   property p_ans; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("access not answered");
endmodule // odc_cfg_chk
bind odc_cfg odc_cfg_chk #(.SW(SW)) u_chk (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_waitrequest, .loop_a_feedback_offset, .loop_a_delta, .loop_b_delta, .loop_c_delta, .timesync_delta,
   .divider_resync, .combo_sum_out, .sync_mode_en, .div_load, .phase_step_apply);
`default_nettype wire

// ### tb/odc_cfg_bench.sv
// Self-checking bench for the output divider configuration block
`default_nettype none
module odc_cfg_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, rdv;
   logic        avs_waitrequest, sync_mode_en, div_load, phase_step_apply, divider_resync = 1'b0;
   logic [39:0] loop_a_feedback_offset = 40'h1;
   logic [39:0] loop_c_delta = 40'h20;
   logic [39:0] loop_b_delta = 40'h300;
   logic [39:0] loop_a_delta = 40'h4000;
   logic [39:0] timesync_delta = 40'h50000;
   logic [39:0] combo_sum_out, div_fraction, div_numerator, div_denominator, e;
   logic [39:0] v [5] = '{40'h1, 40'h20, 40'h300, 40'h4000, 40'h50000};
   logic [8:0]  div_integer;
   logic [9:0]  phase_step;
   logic [15:0] g;
   logic [1:0]  o;
   logic [7:0]  napply = 8'h0, n0;
   int          mismatches = 0, cmp_count = 0;
   odc_cfg #(.SW(40), .OW(39)) u_dut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .loop_a_feedback_offset, .loop_a_delta, .loop_b_delta,
      .loop_c_delta, .timesync_delta, .divider_resync, .combo_sum_out, .sync_mode_en, .div_integer, .div_fraction,
      .div_numerator, .div_denominator, .div_load, .phase_step, .phase_step_apply);
   ////////////////////////////////////////////////////////////
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (phase_step_apply === 1'b1) napply <= napply + 8'h1;
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One bus access; the request stands until waitrequest is seen low
   task automatic acc(input logic w, input logic [3:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic pulse;
      @(posedge ref_clk) divider_resync <= 1'b1;
      @(posedge ref_clk) divider_resync <= 1'b0;
      settle();
   endtask
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      acc(1'b0, 4'h0, 32'h0);
      chk(rdv, 40'h14);
      acc(1'b0, 4'hF, 32'h0);
      chk(rdv, 40'h0);
      chk(div_integer, 40'h14);
      chk(div_denominator, 40'h8000000000);
      acc(1'b1, 4'h0, 32'hFFFF);
      acc(1'b0, 4'h0, 32'h0);
      chk(rdv, 40'hFFF7);
      // Each field sees every code across the loop; swaps show up except feedback offset with time sync, which always share a code
      for (int op = 0; op < 4; op++) begin
         g = 16'h0;
         e = 40'h0;
         for (int k = 0; k < 5; k++) begin
            o = 2'(op + k);
            g = g | (16'(o) << (13 - 2 * k));
            e = e + ((o == 2'h1) ? v[k] : (o == 2'h2) ? -v[k] : 40'h0);
         end
         acc(1'b1, 4'h0, {16'h0, g});
         settle();
         chk(combo_sum_out, e);
      end
      acc(1'b1, 4'h0, {16'h0, g | 16'h8000});
      settle();
      loop_b_delta <= 40'h301;
      settle();
      chk(combo_sum_out, e);
      acc(1'b1, 4'h0, {16'h0, g});
      settle();
      chk(combo_sum_out, e + 40'h1);
      acc(1'b1, 4'h4, 32'h12345678);
      acc(1'b1, 4'h5, 32'h9A);
      acc(1'b1, 4'h6, 32'h1000);
      acc(1'b1, 4'h7, 32'h0);
      acc(1'b1, 4'h8, 32'hFFFFFFFF);
      acc(1'b1, 4'h0, 32'h2);
      acc(1'b1, 4'h9, 32'h1FAB);
      settle();
      chk(sync_mode_en, 40'h1);
      chk(div_integer, 40'h1F);
      chk(div_fraction, 40'hFFFF);
      chk(div_numerator, 40'h9A12345678);
      chk(div_denominator, 40'h1000);
      acc(1'b1, 4'h0, 32'h10);
      acc(1'b1, 4'h9, 32'h1FAB);
      settle();
      chk(div_fraction, 40'hABFFFFFFFF);
      chk(div_numerator, 40'h0);
      chk(div_denominator, 40'h8000000000);
      acc(1'b1, 4'h2, 32'hFFFF);
      acc(1'b0, 4'h2, 32'h0);
      chk(rdv, 40'h3FF);
      acc(1'b1, 4'h2, 32'h3FC);
      n0 = napply;
      acc(1'b1, 4'hC, 32'h1);
      settle();
      chk(napply, n0 + 8'h1);
      chk(phase_step, 40'h3FC);
      pulse();
      chk(napply, n0 + 8'h2);
      acc(1'b1, 4'h0, 32'h0);
      pulse();
      chk(napply, n0 + 8'h2);
      close_out();
   end
endmodule // odc_cfg_bench
`default_nettype wire
